/* File: hdl/lsrc_ctl.sv */
// Controller end: turns user read/write requests into strobe cycles.
// Assumes the memory end shares this clock; status is used unsynchronised.
`timescale 1ns/100ps
module lsrc_ctl
  import lsrc_pkg::*;
#(
  parameter int ADDR_W = LSRC_ADDR_W,
  parameter int DATA_W = LSRC_DATA_W
) (
  // Clock and reset
  input wire logic CLK_IN,
  input wire logic RST_B_IN,
  // User request
  input wire logic REQ_IN,
  input wire logic WRITE_IN,
  input wire logic SEL_IN,
  input wire logic [ADDR_W-1:0] ADDR_IN,
  input wire logic [DATA_W-1:0] WDATA_IN,
  output logic READY_OUT,
  // User answer
  output logic DONE_OUT,
  output logic [DATA_W-1:0] RDATA_OUT,
  // Link
  lsrc_if.ctl LINK
);
  ////////////////////////////////////////////////////////////////////
  lsrc_ctl_state_t st_reg, st_next;
  logic ce_reg, ce_next; // Strobe
  logic cs_reg, cs_next; // Select
  logic we_b_reg, we_b_next; // Active-low write enable
  logic [ADDR_W-1:0] addr_reg, addr_next;
  logic [DATA_W-1:0] wd_reg, wd_next;
  logic oe_reg, oe_next; // Controller drives bus
  logic done_reg, done_next;
  logic [DATA_W-1:0] rd_reg, rd_next;
  // Status seen low since the strobe rose; status is still high on the
  // first strobe edge, so without this the cycle would be cut short
  logic seen_low_reg, seen_low_next;

  ////////////////////////////////////////////////////////////////////
  // Strobe sequencer paced by memory status
  always_comb begin
    st_next = st_reg;
    ce_next = ce_reg;
    cs_next = cs_reg;
    we_b_next = we_b_reg;
    addr_next = addr_reg;
    wd_next = wd_reg;
    oe_next = oe_reg;
    done_next = 1'b0;
    rd_next = rd_reg;
    seen_low_next = seen_low_reg;
    case (st_reg)
      LSRC_C_IDLE: begin
        // Waiting for preset complete avoids cutting it short
        if (REQ_IN && LINK.mem_status) begin
          cs_next = SEL_IN;
          addr_next = ADDR_IN;
          wd_next = WDATA_IN;
          we_b_next = ~WRITE_IN;
          oe_next = WRITE_IN;
          st_next = LSRC_C_SETUP;
        end
      end
      LSRC_C_SETUP: begin
        ce_next = 1'b1;
        st_next = LSRC_C_STROBE;
      end
      LSRC_C_STROBE: begin
        // Status falls the cycle after the edge, so wait for its return
        if (!LINK.mem_status) begin
          seen_low_next = 1'b1;
        end
        if (LINK.mem_status && seen_low_reg) begin
          seen_low_next = 1'b0;
          st_next = LSRC_C_RELEASE;
        end
      end
      LSRC_C_RELEASE: begin
        rd_next = LINK.dq;
        done_next = 1'b1;
        ce_next = 1'b0;
        we_b_next = 1'b1;
        oe_next = 1'b0;
        st_next = LSRC_C_WAIT;
      end
      LSRC_C_WAIT: begin
        // Memory status drops during preset, then back to idle
        st_next = LSRC_C_IDLE;
      end
      default: begin
        st_next = LSRC_C_IDLE;
      end
    endcase
  end

  // Register the sequencer
  always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      st_reg <= LSRC_C_IDLE;
      ce_reg <= 1'b0;
      cs_reg <= 1'b0;
      we_b_reg <= 1'b1;
      addr_reg <= '0;
      wd_reg <= '0;
      oe_reg <= 1'b0;
      done_reg <= 1'b0;
      rd_reg <= '0;
      seen_low_reg <= 1'b0;
    end else begin
      st_reg <= st_next;
      ce_reg <= ce_next;
      cs_reg <= cs_next;
      we_b_reg <= we_b_next;
      addr_reg <= addr_next;
      wd_reg <= wd_next;
      oe_reg <= oe_next;
      done_reg <= done_next;
      rd_reg <= rd_next;
      seen_low_reg <= seen_low_next;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Pin and user outputs
  assign LINK.chip_en = ce_reg;
  assign LINK.chip_sel = cs_reg;
  assign LINK.write_en_b = we_b_reg;
  assign LINK.addr = addr_reg;
  assign LINK.ctl_dq_o = wd_reg;
  assign LINK.ctl_dq_oe = oe_reg;
  assign READY_OUT = (st_reg == LSRC_C_IDLE) & LINK.mem_status;
  assign DONE_OUT = done_reg;
  assign RDATA_OUT = rd_reg;
endmodule : lsrc_ctl

/* File: hdl/lsrc_if.sv */
// Interface joining the memory end and the controller end.
// Resolves the shared data bus from both output enables.
`timescale 1ns/100ps
interface lsrc_if;
  import lsrc_pkg::*;
  logic chip_en; // Cycle strobe, rising edge starts a cycle
  logic chip_sel; // Select, latched at cycle start
  logic write_en_b; // Low writes, high reads
  logic [LSRC_ADDR_W-1:0] addr; // Word address
  logic mem_status; // High when data valid or preset complete
  logic [LSRC_DATA_W-1:0] ctl_dq_o; // Controller drive value
  logic ctl_dq_oe; // Controller drives bus
  logic [LSRC_DATA_W-1:0] mem_dq_o; // Memory drive value
  logic mem_dq_oe; // Memory drives bus
  logic [LSRC_DATA_W-1:0] dq; // Resolved bus level
  // Wired bus; a clash reads as unknown, an idle bus rests at the pull level
  assign dq = ctl_dq_oe ? (mem_dq_oe ? 'x : ctl_dq_o)
                        : (mem_dq_oe ? mem_dq_o : LSRC_DQ_PULL);
  modport mem (input chip_en, chip_sel, write_en_b, addr, dq,
               output mem_status, mem_dq_o, mem_dq_oe);
  modport ctl (output chip_en, chip_sel, write_en_b, addr, ctl_dq_o,
               ctl_dq_oe, input mem_status, dq);
endinterface : lsrc_if

/* File: hdl/lsrc_mem.sv */
// Memory end: 1024 x 4 array working in chip-enable cycles.
// Assumes the controller runs on the same clock, so pins are unsynchronised.
`timescale 1ns/100ps
module lsrc_mem
  import lsrc_pkg::*;
#(
  parameter int ADDR_W = LSRC_ADDR_W,
  parameter int DATA_W = LSRC_DATA_W
) (
  // Clock and reset
  input wire logic CLK_IN,
  input wire logic RST_B_IN,
  // Link
  lsrc_if.mem LINK,
  // Inverted status copy for the user side
  output logic BUSY_OUT
);
  ////////////////////////////////////////////////////////////////////
  logic [DATA_W-1:0] mem_reg [LSRC_DEPTH]; // Storage array
  logic [ADDR_W-1:0] addr_reg, addr_next; // Latched address
  logic sel_reg, sel_next; // Latched select
  logic wr_reg, wr_next; // Write seen during strobe
  logic [DATA_W-1:0] dout_reg, dout_next; // Output latch
  logic oe_reg, oe_next; // Output latch drives bus
  logic ce_reg; // Previous strobe level for edge detect
  logic [LSRC_CNT_W-1:0] cnt_reg, cnt_next; // Access or preset timer
  lsrc_mem_state_t st_reg, st_next;
  logic ce_rise;
  logic do_write;

  assign ce_rise = LINK.chip_en & ~ce_reg;
  assign do_write = (st_reg == LSRC_M_ACCESS) & sel_reg & wr_reg &
                    (cnt_reg == '0);

  ////////////////////////////////////////////////////////////////////
  // Next state of the cycle sequencer
  always_comb begin
    st_next = st_reg;
    addr_next = addr_reg;
    sel_next = sel_reg;
    wr_next = wr_reg;
    dout_next = dout_reg;
    oe_next = oe_reg;
    cnt_next = cnt_reg;
    case (st_reg)
      LSRC_M_PRESET: begin
        // Preset counts down whatever the strobe does; a rise during preset is missed
        if (cnt_reg != '0) begin
          cnt_next = cnt_reg - 1'b1;
        end else begin
          st_next = LSRC_M_IDLE;
        end
      end
      LSRC_M_IDLE: begin
        if (ce_rise) begin
          addr_next = LINK.addr;
          sel_next = LINK.chip_sel;
          wr_next = ~LINK.write_en_b;
          oe_next = 1'b0;
          cnt_next = LSRC_CNT_W'(LSRC_ACCESS_CYC - 1);
          st_next = LSRC_M_ACCESS;
        end
      end
      LSRC_M_ACCESS: begin
        // Write enable may fall while the strobe is high in the first two access cycles
        if (LINK.chip_en && !LINK.write_en_b) begin
          wr_next = 1'b1;
        end
        if (cnt_reg != '0) begin
          cnt_next = cnt_reg - 1'b1;
        end else begin
          st_next = LSRC_M_DONE;
          if (sel_reg && !wr_reg) begin
            dout_next = mem_reg[addr_reg];
            oe_next = 1'b1;
          end
        end
      end
      LSRC_M_DONE: begin
        // Output latch holds until the strobe falls and rises again
        if (!LINK.chip_en) begin
          cnt_next = LSRC_CNT_W'(LSRC_PRESET_CYC - 1);
          st_next = LSRC_M_PRESET;
        end
      end
      default: begin
        st_next = LSRC_M_PRESET;
      end
    endcase
  end

  // Register the sequencer
  always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      st_reg <= LSRC_M_PRESET;
      addr_reg <= '0;
      sel_reg <= 1'b0;
      wr_reg <= 1'b0;
      dout_reg <= '0;
      oe_reg <= 1'b0;
      cnt_reg <= LSRC_CNT_W'(LSRC_PRESET_CYC - 1);
      ce_reg <= 1'b0;
    end else begin
      st_reg <= st_next;
      addr_reg <= addr_next;
      sel_reg <= sel_next;
      wr_reg <= wr_next;
      dout_reg <= dout_next;
      oe_reg <= oe_next;
      cnt_reg <= cnt_next;
      ce_reg <= LINK.chip_en;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Array write at end of access; deselected cycles store nothing
  always_ff @(posedge CLK_IN) begin
    if (do_write) begin
      mem_reg[addr_reg] <= LINK.dq;
    end
  end

  // Output drive and status; drive only for selected reads
  assign LINK.mem_dq_o = dout_reg;
  assign LINK.mem_dq_oe = oe_reg & sel_reg & LINK.write_en_b;
  assign LINK.mem_status = (st_reg == LSRC_M_DONE) |
                           (st_reg == LSRC_M_IDLE);
  assign BUSY_OUT = ~LINK.mem_status;
endmodule : lsrc_mem

/* File: hdl/lsrc_pkg.sv */
// Package for the latched static RAM cycle link: sizes, timing, states.
// Assumes one 100 MHz clock shared by the memory end and controller end.
//
// Functional notes
// - Array holds 1024 words of four bits.
// - Every cycle starts on chip-enable rising edge.
// - Controller drops chip enable after completion.
// - Address and select latched at cycle start.
// - Read data latched until next cycle.
// - Write enable stays high during reads.
// - Write enable low while chip enable high.
// - Data shares one tri-state four-bit bus.
// - Status shows data valid and preset done.
// - Controller may time strobes from status.
package lsrc_pkg;
  // Array geometry
  localparam int LSRC_ADDR_W = 10;
  localparam int LSRC_DATA_W = 4;
  localparam int LSRC_DEPTH = 1024;
  // Access and preset times in ns, and cycles derived at 100 MHz
  localparam int LSRC_CLK_NS = 10;
  localparam int LSRC_ACCESS_NS = 30;
  localparam int LSRC_PRESET_NS = 20;
  localparam int LSRC_ACCESS_CYC =
    (LSRC_ACCESS_NS + LSRC_CLK_NS - 1) / LSRC_CLK_NS;
  localparam int LSRC_PRESET_CYC =
    (LSRC_PRESET_NS + LSRC_CLK_NS - 1) / LSRC_CLK_NS;
  localparam int LSRC_CNT_W = 4;
  // Level the shared bus settles to when neither end drives it (pull-up)
  localparam logic [LSRC_DATA_W-1:0] LSRC_DQ_PULL = {LSRC_DATA_W{1'b1}};
  // Memory end states
  typedef enum logic [1:0] {
    LSRC_M_PRESET,
    LSRC_M_IDLE,
    LSRC_M_ACCESS,
    LSRC_M_DONE
  } lsrc_mem_state_t;
  // Controller end states
  typedef enum logic [2:0] {
    LSRC_C_IDLE,
    LSRC_C_SETUP,
    LSRC_C_STROBE,
    LSRC_C_RELEASE,
    LSRC_C_WAIT
  } lsrc_ctl_state_t;
endpackage : lsrc_pkg

/* File: tb/lsrc_monitor.sv */
// Checker for the strobe link between the memory and controller ends.
// Assumes one clock and an active-low asynchronous reset.
`timescale 1ns/100ps
module lsrc_monitor
  import lsrc_pkg::*;
(
  // Clock and reset
  input wire logic CLK_IN,
  input wire logic RST_B_IN,
  // Link signals
  input wire logic chip_en,
  input wire logic chip_sel,
  input wire logic write_en_b,
  input wire logic mem_status,
  input wire logic ctl_dq_oe,
  input wire logic mem_dq_oe,
  input wire logic [LSRC_DATA_W-1:0] mem_dq_o
);
  default clocking cb @(posedge CLK_IN);
  endclocking
  default disable iff (!RST_B_IN);
  ////////////////////////////////////////
  // A cycle opens on a strobe rise with preset done
  sequence s_open;
    $rose(chip_en) && mem_status;
  endsequence
  // Status low for the access, then data valid
  sequence s_access;
    !mem_status [*3] ##[1:2] mem_status;
  endsequence
  a_status_access: assert property (s_open |=> s_access)
    else $error("status did not follow the access");
  a_preset_done: assert property (
    $fell(chip_en) |=> !mem_status ##[1:3] mem_status)
    else $error("preset interval not shown on status");
  a_strobe_ready: assert property ($rose(chip_en) |-> mem_status)
    else $error("strobe rose before preset done");
  a_strobe_drops: assert property (
    $rose(chip_en) |-> ##[1:12] $fell(chip_en))
    else $error("strobe not returned low");
  a_no_clash: assert property (!(mem_dq_oe && ctl_dq_oe))
    else $error("both ends drive the data bus");
  a_write_quiet: assert property (
    !write_en_b && chip_en |-> ctl_dq_oe && !mem_dq_oe)
    else $error("memory drives during a write");
  a_write_drive: assert property (
    $rose(chip_en) && !write_en_b |-> ctl_dq_oe)
    else $error("write strobe without write data");
  a_we_steady: assert property (
    chip_en && $past(chip_en) |-> $stable(write_en_b))
    else $error("write enable moved inside a strobe");
  // Deselected cycle must leave the bus undriven for the whole access
  a_desel_quiet: assert property (
    s_open and !chip_sel |=> !mem_dq_oe [*6])
    else $error("deselected memory drove the bus");
  a_dout_held: assert property (
    mem_dq_oe && $past(mem_dq_oe) && !chip_en |-> $stable(mem_dq_o))
    else $error("latched read data changed");
endmodule : lsrc_monitor

/* File: tb/testbench.sv */
// Testbench: both link ends joined; user side driven and judged.
// Assumes a 100 MHz clock and the package array geometry.
`timescale 1ns/100ps
module testbench;
  import lsrc_pkg::*;
  logic clk = 1'h0; // Clock
  logic rst_b = 1'h0; // Reset, active low
  logic req = 1'h0; // Request level
  logic wr = 1'h0; // Write select
  logic sel = 1'h0; // Chip select
  logic [LSRC_ADDR_W-1:0] addr = 10'h000; // Word address
  logic [LSRC_DATA_W-1:0] wdata = 4'h0; // Write data
  logic [LSRC_DATA_W-1:0] rdata; // Read data out
  logic [LSRC_DATA_W-1:0] got; // Read data taken at done
  logic ready; // Controller ready
  logic done; // Completion pulse
  logic busy; // Memory busy copy
  int num_errors = 0; // Mismatches
  int tests_run = 0; // Comparisons
  lsrc_if link();
  lsrc_mem u_lsrc_mem (.CLK_IN(clk), .RST_B_IN(rst_b), .LINK(link.mem),
    .BUSY_OUT(busy));
  lsrc_ctl u_lsrc_ctl (.CLK_IN(clk), .RST_B_IN(rst_b), .REQ_IN(req),
    .WRITE_IN(wr), .SEL_IN(sel), .ADDR_IN(addr), .WDATA_IN(wdata),
    .READY_OUT(ready), .DONE_OUT(done), .RDATA_OUT(rdata), .LINK(link.ctl));
  lsrc_monitor u_mon (.CLK_IN(clk), .RST_B_IN(rst_b),
    .chip_en(link.chip_en), .chip_sel(link.chip_sel),
    .write_en_b(link.write_en_b), .mem_status(link.mem_status),
    .ctl_dq_oe(link.ctl_dq_oe), .mem_dq_oe(link.mem_dq_oe),
    .mem_dq_o(link.mem_dq_o));
  ////////////////////////////////////////
  // Free-running clock
  always #5 clk = ~clk;
  // Compare a four-bit result
  task automatic chk(input logic [3:0] g, input logic [3:0] e);
    tests_run++;
    if (g !== e) begin
      num_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  // One transfer; bounded waits so a stall shows as a mismatch
  task automatic op(input logic w, input logic s, input logic [9:0] a,
    input logic [3:0] d);
    int n;
    n = 0;
    @(posedge clk);
    req <= 1'h1;
    wr <= w;
    sel <= s;
    addr <= a;
    wdata <= d;
    do @(negedge clk); while (ready !== 1'h1 && ++n < 40);
    @(posedge clk);
    req <= 1'h0;
    do @(negedge clk); while (done !== 1'h1 && ++n < 80);
    chk({3'h0, done}, 4'h1);
    got = rdata;
  endtask : op
  ////////////////////////////////////////
  // Idle levels during reset, then ready after preset
  task automatic t_reset();
    repeat (12) @(posedge clk);
    chk({3'h0, link.chip_en}, 4'h0);
    chk({3'h0, link.write_en_b}, 4'h1);
    chk({3'h0, link.mem_dq_oe}, 4'h0);
    chk({3'h0, ready}, 4'h0);
    rst_b <= 1'h1;
    repeat (6) @(negedge clk);
    chk({3'h0, link.mem_status}, 4'h1);
    chk({3'h0, busy}, 4'h0);
    chk({3'h0, ready}, 4'h1);
    $display("reset test done");
  endtask : t_reset
  // Back-to-back writes then reads at both address extremes and two alternating-bit addresses
  task automatic t_wr_rd();
    logic [9:0] at [4] = '{10'h000, 10'h3FF, 10'h155, 10'h2AA};
    logic [3:0] dt [4] = '{4'hA, 4'h5, 4'hF, 4'h0};
    for (int i = 0; i < 4; i++) op(1'h1, 1'h1, at[i], dt[i]);
    for (int i = 0; i < 4; i++) begin
      op(1'h0, 1'h1, at[i], 4'h0);
      chk(got, dt[i]);
    end
    $display("write read test done");
  endtask : t_wr_rd
  // A deselected write must leave the word untouched
  task automatic t_desel();
    op(1'h1, 1'h0, 10'h155, 4'h3);
    op(1'h0, 1'h1, 10'h155, 4'h0);
    chk(got, 4'hF);
    // Deselected read after a read: memory must release the bus
    op(1'h0, 1'h0, 10'h000, 4'h0);
    chk(got, LSRC_DQ_PULL);
    $display("deselect test done");
  endtask : t_desel
  // Read data stays on the bus after the strobe ends
  task automatic t_hold();
    op(1'h0, 1'h1, 10'h3FF, 4'h0);
    repeat (5) @(negedge clk);
    chk(link.dq, 4'h5);
    chk(rdata, 4'h5);
    chk({3'h0, link.mem_status}, 4'h1);
    $display("hold test done");
  endtask : t_hold
  // Verdict; the single place where the run ends
  task automatic wrap_up();
    $display("checks=%0d errors=%0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : wrap_up
  ////////////////////////////////////////
  // Main sequence
  initial begin
    t_reset();
    t_wr_rd();
    t_desel();
    t_hold();
    wrap_up();
  end
  // Watchdog: 12 transfers of about 11 cycles each, with wide margin
  initial begin
    #50000;
    num_errors++;
    wrap_up();
  end
endmodule : testbench
